/* File: osp_cfg.svh */
`ifndef OSP_CFG_SVH
`define OSP_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define OSP_A_PC1     8'h00
`define OSP_A_PC2     8'h01
`define OSP_A_PC3     8'h02
`define OSP_A_TC      8'h03
`define OSP_A_DON     8'h05
`define OSP_A_DOF     8'h06
`define OSP_A_VOS     8'h07
`define OSP_A_CLS     8'h08
`define OSP_A_RUN     8'h15
`define OSP_A_ST      8'h16
// ****************************************
// Reset values
// ****************************************
`define OSP_R_PC1     8'h1F
`define OSP_R_PC2     8'h00
`define OSP_R_PC3     8'h00
`define OSP_R_TC      8'h11
`define OSP_R_DON     8'h00
`define OSP_R_DOF     8'h00
`define OSP_R_VOS     8'h28
`define OSP_R_CLS     8'hF0
`define OSP_R_RUN     8'h00
`define OSP_R_ST      8'hFF
// ****************************************
// Field positions (status and enables)
// ****************************************
`define OSP_B_OV      0
`define OSP_B_UV      1
`define OSP_B_OC      2
`define OSP_B_OT      3
`define OSP_B_TR      4
`define OSP_B_PG      5
`define OSP_B_LAT_VUC 5
`define OSP_B_LAT_OT  6
`define OSP_B_LAT_TR  7
`define OSP_B_PG_LO   6
// ****************************************
// Setpoint map, levels in 12.5 mV units
// ****************************************
`define OSP_C_SUB1    8'h78
`define OSP_C_SUB2    8'hFA
`define OSP_L_BASE1   9'h028
`define OSP_L_BASE2   9'h0A0
`define OSP_L_BASE3   9'h1A4
`define OSP_L_OV_MIN  10'h050
`define OSP_L_TRK     10'h014
// ****************************************
// Percentages
// ****************************************
`define OSP_P_UNIT    8'h64
`define OSP_P_OV_BASE 8'h6E
`define OSP_P_UV_BASE 8'h4B
`define OSP_P_STEP    8'h05
`define OSP_P_PG_HI   8'h6E
`define OSP_P_PG_LO0  8'h5A
`define OSP_P_PG_LO1  8'h5F
// ****************************************
// Timing
// ****************************************
`define OSP_CLK_MHZ     125
`define OSP_DLY_TICK_US 1000
`define OSP_RETRY_MS    130
`define OSP_DLY_TICK_CYC (`OSP_DLY_TICK_US * `OSP_CLK_MHZ)
`define OSP_RETRY_CYC   (`OSP_RETRY_MS * 1000 * `OSP_CLK_MHZ)
`define OSP_MCLK_CYC    125
`endif

/* File: osp_pkg.sv */
package osp_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} osp_bus_req_t;
	typedef enum logic [2:0] {
		S_OFF, S_ON_DLY, S_RAMP_UP, S_STEADY, S_OFF_DLY, S_RAMP_DN, S_TRIP
	} osp_state_t;
endpackage

/* File: osp_top.sv */
// Summary of operation
// - 256 setpoint codes span 0.5 V to 5.5 V
// - Three sub-ranges: 12.5, 25, 50 mV steps
// - Written setpoint code becomes regulation target
// - Nonzero slope lowers output as current rises
// - Delays and slew rates are software programmable
// - Wait turn-on delay before ramping up
// - Slewed turn-off delay ends at zero output
// - Unslewed turn-off delay ends with switches off
// - Ramps move in 12.5 mV steps
// - Step duration divides the master clock
// - Protection states readable in status register
// - Thresholds scale with the active setpoint
// - Each protection latching, non-latching or disabled
// - Non-latching trips retry every 130 ms
// - Latching trips stay off, restart conditions
// - Events grouped as warnings, faults, errors
// - Reset reloads all setup register defaults
// - Tripped protection drives its status bit low
//
// The address map and the plain strobed port were chosen for this implementation.
`include "osp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module osp_top #(
	parameter int unsigned DLY_TICK_CYC = `OSP_DLY_TICK_CYC,
	parameter int unsigned RETRY_CYC    = `OSP_RETRY_CYC,
	parameter int unsigned MCLK_CYC     = `OSP_MCLK_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire osp_pkg::osp_bus_req_t bus_req,
	output logic [7:0]                rd_data,
	input  wire logic                 mclk_pin,
	input  wire logic [9:0]           vout_meas,
	input  wire logic [7:0]           iout_meas,
	input  wire logic                 ot_hot,
	output logic [8:0]                vref_lvl,
	output logic                      hs_en,
	output logic                      ls_en,
	output logic                      pgood_o,
	output logic                      pgood_oe,
	output logic                      ramp_done
);
	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [8:0] code2lvl(input logic [7:0] c);
		logic [7:0] d;
		d = 8'h00;
		if (c <= `OSP_C_SUB1) begin
			return `OSP_L_BASE1 + {1'b0, c};
		end else if (c <= `OSP_C_SUB2) begin
			d = c - `OSP_C_SUB1;
			return `OSP_L_BASE2 + {d, 1'b0};
		end
		d = c - `OSP_C_SUB2;
		return `OSP_L_BASE3 + {d[6:0], 2'b00};
	endfunction

	function automatic logic [17:0] scl(input logic [9:0] v, input logic [7:0] k);
		return 18'(v) * 18'(k);
	endfunction

	// ****************************************
	// Registers and bus
	// ****************************************
	logic [7:0] pc1, pc2, pc3, tc, turn_on_delay_reg, turn_off_delay_reg, output_setpoint_reg, current_limit_reg, run, st;
	osp_pkg::osp_state_t state, next_state;
	logic [31:0] dly_cnt, next_dly;
	logic [8:0]  cur_lvl, next_lvl;
	logic [3:0]  step_cnt;
	logic [4:0]  trip_mask;
	logic        trip_lat, trip_pend, run_cyc, ov_hold;
	logic [2:0]  mclk_sync;

	wire wr_hit = bus_req.wr;
	wire wr_st  = wr_hit && bus_req.addr == `OSP_A_ST;
	wire [7:0] rd_mux =
		bus_req.addr == `OSP_A_PC1 ? pc1 :
		bus_req.addr == `OSP_A_PC2 ? pc2 :
		bus_req.addr == `OSP_A_PC3 ? pc3 :
		bus_req.addr == `OSP_A_TC  ? tc  :
		bus_req.addr == `OSP_A_DON ? turn_on_delay_reg :
		bus_req.addr == `OSP_A_DOF ? turn_off_delay_reg :
		bus_req.addr == `OSP_A_VOS ? output_setpoint_reg :
		bus_req.addr == `OSP_A_CLS ? current_limit_reg :
		bus_req.addr == `OSP_A_RUN ? run :
		bus_req.addr == `OSP_A_ST  ? st  : 8'h00;

	// Defaults come back only through reset; nothing is kept across power loss
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc1 <= `OSP_R_PC1;
			pc2 <= `OSP_R_PC2;
			pc3 <= `OSP_R_PC3;
			tc  <= `OSP_R_TC;
			turn_on_delay_reg <= `OSP_R_DON;
			turn_off_delay_reg <= `OSP_R_DOF;
			output_setpoint_reg <= `OSP_R_VOS;
			current_limit_reg <= `OSP_R_CLS;
			run <= `OSP_R_RUN;
		end else if (wr_hit) begin
			unique case (bus_req.addr)
				`OSP_A_PC1: pc1 <= bus_req.wdata;
				`OSP_A_PC2: pc2 <= bus_req.wdata;
				`OSP_A_PC3: pc3 <= bus_req.wdata;
				`OSP_A_TC:  tc  <= bus_req.wdata;
				`OSP_A_DON: turn_on_delay_reg <= bus_req.wdata;
				`OSP_A_DOF: turn_off_delay_reg <= bus_req.wdata;
				`OSP_A_VOS: output_setpoint_reg <= bus_req.wdata;
				`OSP_A_CLS: current_limit_reg <= bus_req.wdata;
				`OSP_A_RUN: run <= bus_req.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= bus_req.rd ? rd_mux : 8'h00;
		end
	end

	// ****************************************
	// Setpoint, droop and thresholds
	// ****************************************
	wire [8:0]  set_lvl = code2lvl(output_setpoint_reg);
	wire [11:0] droop_w = 12'(iout_meas) * 12'(current_limit_reg[3:0]);
	wire [8:0]  droop   = {1'b0, droop_w[11:4]};
	wire [8:0]  next_vref = cur_lvl > droop ? cur_lvl - droop : 9'h000;
	wire [2:0]  ov_sel  = pc2[2] ? 3'h4 : pc2[2:0];
	wire [7:0]  ov_pct  = `OSP_P_OV_BASE + 8'(ov_sel) * `OSP_P_STEP;
	wire [7:0]  uv_pct  = `OSP_P_UV_BASE + 8'(pc2[5:4]) * `OSP_P_STEP;
	wire [7:0]  pg_lo   = pc2[`OSP_B_PG_LO] ? `OSP_P_PG_LO1 : `OSP_P_PG_LO0;
	wire [17:0] v_scl   = scl(vout_meas, `OSP_P_UNIT);
	wire [9:0]  lvl10   = {1'b0, set_lvl};
	// Thresholds move with every setpoint change
	wire ov_raw = v_scl > scl(lvl10, ov_pct) && vout_meas > `OSP_L_OV_MIN;
	wire uv_raw = v_scl < scl(lvl10, uv_pct);
	wire pg_in  = v_scl >= scl(lvl10, pg_lo) && v_scl <= scl(lvl10, `OSP_P_PG_HI);
	wire oc_raw = iout_meas >= {current_limit_reg[7:4], 4'h0} && uv_raw;
	wire [9:0] trk_d = vout_meas > {1'b0, cur_lvl} ?
		vout_meas - {1'b0, cur_lvl} : {1'b0, cur_lvl} - vout_meas;
	wire tr_raw = trk_d > `OSP_L_TRK;

	// ****************************************
	// Protection classification
	// ****************************************
	wire on_st = state inside {osp_pkg::S_RAMP_UP, osp_pkg::S_STEADY,
		osp_pkg::S_OFF_DLY, osp_pkg::S_RAMP_DN};
	wire steady = state == osp_pkg::S_STEADY;
	wire [4:0] raw_vec = {tr_raw && state == osp_pkg::S_RAMP_UP, ot_hot,
		oc_raw && on_st, uv_raw && steady, ov_raw && on_st};
	wire [4:0] trip_vec = state == osp_pkg::S_TRIP ? 5'h00 : raw_vec & pc1[4:0];
	wire any_trip = |trip_vec;
	// Errors and fast faults drop the high side at once, and the low side too except on OV; UV and OT ramp down unless fall_n is zero
	wire fast_trip = trip_vec[`OSP_B_OV] | trip_vec[`OSP_B_OC] | trip_vec[`OSP_B_TR];
	wire lat_new = ((trip_vec[`OSP_B_OV] | trip_vec[`OSP_B_UV] | trip_vec[`OSP_B_OC])
		& pc1[`OSP_B_LAT_VUC]) | (trip_vec[`OSP_B_OT] & pc1[`OSP_B_LAT_OT])
		| (trip_vec[`OSP_B_TR] & pc1[`OSP_B_LAT_TR]);
	// Only OV and OT can persist once switches are off
	wire [4:0] cause_now = {3'b000, ot_hot, ov_raw} & trip_mask;
	wire st_clear = &st[4:0] | ~|(~st[4:0] & trip_mask);
	wire restart = run[0] && cause_now == 5'h00 && dly_cnt == 32'h0 &&
		(!trip_lat || st_clear || run_cyc);
	wire [4:0] next_st = ((st[4:0] | (wr_st ? bus_req.wdata[4:0] : 5'h00) |
		(state == osp_pkg::S_TRIP && restart && !trip_lat ? trip_mask : 5'h00))
		& ~trip_vec);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= `OSP_R_ST;
		end else begin
			st <= {2'b11, steady && pg_in, next_st};
		end
	end

	// ****************************************
	// Master clock divider
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mclk_sync <= 3'h0;
		end else begin
			mclk_sync <= {mclk_sync[1:0], mclk_pin};
		end
	end

	wire mclk_rise = mclk_sync[1] && !mclk_sync[2];
	wire [3:0] fall_n = tc[7:4];
	wire [3:0] step_len = state == osp_pkg::S_RAMP_DN ? fall_n : tc[3:0];
	wire step_tick = mclk_rise && step_cnt >= step_len;

	always_ff @(posedge clk) begin
		if (!rst_n || state != next_state) begin
			step_cnt <= 4'h0;
		end else if (mclk_rise) begin
			step_cnt <= step_tick ? 4'h0 : step_cnt + 4'h1;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	wire [31:0] ramp_cyc = 32'(cur_lvl) * (32'(fall_n) + 32'h1) * MCLK_CYC;
	wire [8:0]  lvl_up = cur_lvl + 9'h001;
	wire [8:0]  lvl_dn = cur_lvl - 9'h001;
	wire [8:0]  lvl_trk = cur_lvl < set_lvl ? lvl_up :
		cur_lvl > set_lvl ? lvl_dn : cur_lvl;

	always_comb begin
		next_state = state;
		next_dly   = dly_cnt == 32'h0 ? 32'h0 : dly_cnt - 32'h1;
		next_lvl   = cur_lvl;
		unique case (state)
			osp_pkg::S_OFF: begin
				next_lvl = 9'h000;
				if (run[0]) begin
					next_state = osp_pkg::S_ON_DLY;
					next_dly   = 32'(turn_on_delay_reg) * DLY_TICK_CYC;
				end
			end
			osp_pkg::S_ON_DLY: begin
				if (!run[0]) begin
					next_state = osp_pkg::S_OFF;
				end else if (dly_cnt == 32'h0) begin
					next_state = osp_pkg::S_RAMP_UP;
				end
			end
			osp_pkg::S_RAMP_UP, osp_pkg::S_STEADY: begin
				if (step_tick) begin
					next_lvl = lvl_trk;
				end
				if (!run[0]) begin
					next_state = osp_pkg::S_OFF_DLY;
					next_dly   = 32'(turn_off_delay_reg) * DLY_TICK_CYC;
				end else if (state == osp_pkg::S_RAMP_UP && cur_lvl == set_lvl) begin
					next_state = osp_pkg::S_STEADY;
				end
			end
			osp_pkg::S_OFF_DLY: begin
				// Pre-ramp wait only stays positive if the off delay covers the ramp
				if (fall_n == 4'h0) begin
					if (dly_cnt == 32'h0) begin
						next_state = osp_pkg::S_OFF;
					end
				end else if (dly_cnt <= ramp_cyc) begin
					next_state = osp_pkg::S_RAMP_DN;
				end
			end
			osp_pkg::S_RAMP_DN: begin
				if (cur_lvl == 9'h000) begin
					next_state = trip_pend ? osp_pkg::S_TRIP : osp_pkg::S_OFF;
					next_dly   = RETRY_CYC;
				end else if (step_tick) begin
					next_lvl = lvl_dn;
				end
			end
			osp_pkg::S_TRIP: begin
				next_lvl = 9'h000;
				if (!run[0] && dly_cnt == 32'h0) begin
					next_state = osp_pkg::S_OFF;
				end else if (restart) begin
					next_state = osp_pkg::S_ON_DLY;
					next_dly   = 32'(turn_on_delay_reg) * DLY_TICK_CYC;
				end else if (dly_cnt == 32'h0 && !trip_lat) begin
					next_dly = RETRY_CYC;
				end
			end
		endcase
		if (any_trip) begin
			next_dly = RETRY_CYC;
			if (fast_trip || fall_n == 4'h0) begin
				next_state = osp_pkg::S_TRIP;
				next_lvl   = 9'h000;
			end else begin
				next_state = osp_pkg::S_RAMP_DN;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state     <= osp_pkg::S_OFF;
			dly_cnt   <= 32'h0;
			cur_lvl   <= 9'h000;
			trip_mask <= 5'h00;
			trip_lat  <= 1'b0;
			trip_pend <= 1'b0;
			run_cyc   <= 1'b0;
			ov_hold   <= 1'b0;
		end else begin
			state     <= next_state;
			dly_cnt   <= next_dly;
			cur_lvl   <= next_lvl;
			trip_mask <= any_trip ? trip_vec : trip_mask;
			trip_lat  <= any_trip ? lat_new : trip_lat;
			trip_pend <= any_trip ? 1'b1 : (state == osp_pkg::S_RAMP_DN ? trip_pend : 1'b0);
			run_cyc   <= any_trip ? 1'b0 : (run_cyc | !run[0]);
			ov_hold   <= any_trip ? trip_vec[`OSP_B_OV] :
				(next_state == osp_pkg::S_TRIP && ov_hold);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	wire next_on = next_state inside {osp_pkg::S_RAMP_UP, osp_pkg::S_STEADY,
		osp_pkg::S_OFF_DLY, osp_pkg::S_RAMP_DN};
	wire next_ov = any_trip ? trip_vec[`OSP_B_OV] : next_state == osp_pkg::S_TRIP && ov_hold;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vref_lvl  <= 9'h000;
			hs_en     <= 1'b0;
			ls_en     <= 1'b0;
			pgood_o   <= 1'b0;
			pgood_oe  <= 1'b1;
			ramp_done <= 1'b0;
		end else begin
			vref_lvl  <= next_vref;
			hs_en     <= next_on;
			// OV keeps the low side on to drain the output filter
			ls_en     <= next_on || next_ov;
			pgood_o   <= 1'b0;
			pgood_oe  <= !(steady && pg_in);
			ramp_done <= state == osp_pkg::S_RAMP_UP && next_state == osp_pkg::S_STEADY;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_LVL_RANGE: assert property (set_lvl >= 9'h028 && set_lvl <= 9'h1B8)
		else $error("setpoint level out of range");
	AST_TOP_CODE: assert property (wr_hit && bus_req.addr == `OSP_A_VOS &&
		bus_req.wdata == 8'hFB |=> set_lvl == 9'h1A8)
		else $error("setpoint map wrong in top sub-range");
	AST_STATUS_LOW: assert property (any_trip |=> (st[4:0] & $past(trip_vec)) == 5'h00)
		else $error("tripped status bit not low");
	AST_RAMP_STEP: assert property (state == osp_pkg::S_RAMP_UP && step_tick &&
		next_state == osp_pkg::S_RAMP_UP && cur_lvl < set_lvl |=> cur_lvl == $past(lvl_up))
		else $error("ramp step not one unit");
	AST_TICK_MCLK: assert property (cur_lvl != $past(cur_lvl) && $past(state) != osp_pkg::S_TRIP
		&& $past(state) != osp_pkg::S_OFF
		&& $past(!any_trip) |-> $past(mclk_rise))
		else $error("level moved without master clock edge");
	AST_ON_DELAY: assert property ($rose(state == osp_pkg::S_RAMP_UP) |->
		$past(state) == osp_pkg::S_ON_DLY && $past(dly_cnt) == 32'h0)
		else $error("ramp started before turn-on delay");
	AST_NOSLEW_OFF: assert property (state == osp_pkg::S_OFF_DLY && fall_n == 4'h0 &&
		dly_cnt == 32'h0 && !any_trip |=> state == osp_pkg::S_OFF ##1 !hs_en)
		else $error("switches not off at end of off delay");
	AST_RAMP_DN_START: assert property ($rose(state == osp_pkg::S_RAMP_DN) && !trip_pend |->
		$past(dly_cnt) <= $past(ramp_cyc))
		else $error("ramp down started too early");
	AST_RETRY_HOLD: assert property (state == osp_pkg::S_TRIP && dly_cnt != 32'h0
		&& run[0] |=> state == osp_pkg::S_TRIP)
		else $error("restart before retry interval");
	AST_DONE: assert property (ramp_done |-> state == osp_pkg::S_STEADY &&
		$past(cur_lvl) == $past(set_lvl))
		else $error("ramp done without reaching target");
	AST_DROOP: assert property ($past(droop) != 9'h000 && $past(cur_lvl) > $past(droop)
		|-> vref_lvl < $past(cur_lvl))
		else $error("no droop under load");
endmodule // osp_top
`default_nettype wire

/* File: osp_mgr_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Power manager and load model
// ****************************************
module osp_mgr_model #(
	parameter int unsigned MCLK_CYC = 4
) (
	input  wire logic       clk,
	input  wire logic [8:0] vref_lvl,
	input  wire logic [9:0] bump,
	output logic            mclk_pin,
	output logic [9:0]      vout_meas
);
	int unsigned div_cnt = 0;
	initial mclk_pin = 1'b0;
	initial vout_meas = 10'h000;
	// Free-running, so every converter on the bus steps on the same base
	always @(posedge clk) begin
		div_cnt <= (div_cnt + 1) % MCLK_CYC;
		mclk_pin <= (div_cnt < MCLK_CYC / 2);
	end
	// Single converter on its own, so no parallel group is needed before margining
	// Stiff load: output trails the reference by a cycle, plus an injected error
	always @(posedge clk) begin
		vout_meas <= {1'b0, vref_lvl} + bump;
	end
endmodule // osp_mgr_model
`default_nettype wire

/* File: tb_output_sequencing_protection.sv */
`include "osp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_output_sequencing_protection;
	localparam int MCLK = 4;
	localparam int TICK = 10;
	localparam int RETRY = 50;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	osp_pkg::osp_bus_req_t bus_req = '0;
	logic [7:0]            rd_data;
	logic                  mclk_pin;
	logic [9:0]            vout_meas;
	logic [9:0]            bump = 10'h000;
	logic [7:0]            iout_meas = 8'h00;
	logic                  ot_hot = 1'b0;
	logic [8:0]            vref_lvl;
	logic                  hs_en;
	logic                  ls_en;
	logic                  ramp_done;
	logic                  pgood_o;
	logic                  pgood_oe;
	logic [8:0]            snap_vref;
	logic                  snap_ls;
	int                    err_count = 0;
	int                    checks_done = 0;
	int                    cyc = 0;
	int                    n;

	always #4 clk = ~clk;

	osp_top #(.DLY_TICK_CYC(TICK), .RETRY_CYC(RETRY), .MCLK_CYC(MCLK)) osp_top_inst (
		.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.mclk_pin(mclk_pin), .vout_meas(vout_meas), .iout_meas(iout_meas),
		.ot_hot(ot_hot), .vref_lvl(vref_lvl), .hs_en(hs_en), .ls_en(ls_en),
		.pgood_o(pgood_o), .pgood_oe(pgood_oe), .ramp_done(ramp_done)
	);
	osp_mgr_model #(.MCLK_CYC(MCLK)) osp_mgr_model_inst (
		.clk(clk), .vref_lvl(vref_lvl), .bump(bump), .mclk_pin(mclk_pin),
		.vout_meas(vout_meas)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic close_out();
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int k, input int lo, input int hi);
		checks_done++;
		if (k < lo || k > hi) begin
			err_count++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, k, lo, hi);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		@(negedge clk);
		chk({2'b00, rd_data & m}, {2'b00, e & m});
		@(posedge clk);
	endtask
	// Snapshots are taken at the falling edge so the caller never races the clock
	task automatic wait_sig(input int sel, input logic v, input int lim, output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
			snap_vref = vref_lvl;
			snap_ls = ls_en;
		end while (((sel == 1) ? ramp_done : hs_en) !== v && k < lim);
		if (k == lim) begin
			err_count++;
			$display("[ERR] %0t wait limit reached", $time);
		end
		@(posedge clk);
	endtask
	task automatic power_on(input logic [7:0] code);
		bus_wr(`OSP_A_VOS, code);
		bus_wr(`OSP_A_RUN, 8'h01);
		wait_sig(1, 1'b1, 8000, n);
	endtask
	task automatic power_off();
		bus_wr(`OSP_A_RUN, 8'h00);
		wait_sig(0, 1'b0, 8000, n);
	endtask
	function automatic logic [9:0] lvl(input logic [7:0] c);
		if (c <= 8'h78) return 10'h028 + c;
		if (c <= 8'hFA) return 10'h0A0 + 10'h002 * (c - 8'h78);
		return 10'h1A4 + 10'h004 * (c - 8'hFA);
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [7:0] ra [11] = '{`OSP_A_PC1, `OSP_A_PC2, `OSP_A_PC3, `OSP_A_TC, `OSP_A_DON,
			`OSP_A_DOF, `OSP_A_VOS, `OSP_A_CLS, `OSP_A_RUN, `OSP_A_ST, 8'h04};
		logic [7:0] rv [11] = '{8'h1F, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h28, 8'hF0,
			8'h00, 8'hFF, 8'h00};
		for (int i = 0; i < 11; i++) begin
			bus_rd(ra[i], rv[i], (ra[i] == `OSP_A_ST) ? 8'hDF : 8'hFF);
		end
	endtask
	task automatic t_setpoint();
		logic [7:0] codes [6] = '{8'h00, 8'h78, 8'h79, 8'hFA, 8'hFB, 8'hFF};
		logic [8:0] prev;
		int         gap;
		int         steps;
		bus_wr(`OSP_A_TC, 8'h01);
		foreach (codes[i]) begin
			bus_wr(`OSP_A_VOS, codes[i]);
			bus_wr(`OSP_A_RUN, 8'h01);
			@(negedge clk);
			prev = vref_lvl;
			gap = 0;
			steps = 0;
			repeat (8000) begin
				@(negedge clk);
				gap++;
				if (vref_lvl !== prev) begin
					chk({1'b0, vref_lvl}, {1'b0, prev} + 10'h001);
					if (steps > 0) chk_rng(gap, 2 * MCLK, 2 * MCLK);
					prev = vref_lvl;
					gap = 0;
					steps++;
				end
				if (ramp_done === 1'b1) break;
			end
			chk({1'b0, vref_lvl}, lvl(codes[i]));
			@(negedge clk);
			chk({9'h000, ramp_done}, 10'h000);
			@(posedge clk);
			power_off();
		end
	endtask
	task automatic t_delays();
		bus_wr(`OSP_A_TC, 8'h11);
		bus_wr(`OSP_A_DON, 8'h03);
		bus_wr(`OSP_A_VOS, 8'h00);
		bus_wr(`OSP_A_RUN, 8'h01);
		wait_sig(0, 1'b1, 100, n);
		chk_rng(n, 3 * TICK, 3 * TICK + 6);
		wait_sig(1, 1'b1, 2000, n);
		bus_wr(`OSP_A_DOF, 8'h28);
		bus_wr(`OSP_A_RUN, 8'h00);
		repeat (40) @(negedge clk);
		chk({1'b0, vref_lvl}, 10'h028);
		@(posedge clk);
		wait_sig(0, 1'b0, 600, n);
		chk_rng(n, 350, 380);
		chk({1'b0, snap_vref}, 10'h000);
		bus_wr(`OSP_A_TC, 8'h01);
		bus_wr(`OSP_A_DON, 8'h00);
		bus_wr(`OSP_A_DOF, 8'h02);
		power_on(8'h00);
		bus_wr(`OSP_A_RUN, 8'h00);
		wait_sig(0, 1'b0, 100, n);
		chk_rng(n, 2 * TICK - 2, 2 * TICK + 4);
	endtask
	task automatic t_droop();
		power_on(8'h28);
		iout_meas <= 8'h28;
		bus_wr(`OSP_A_CLS, 8'hF4);
		repeat (4) @(negedge clk);
		chk({1'b0, vref_lvl}, 10'h046);
		chk({9'h000, pgood_oe}, 10'h001);
		@(posedge clk);
		iout_meas <= 8'h00;
		repeat (4) @(negedge clk);
		chk({1'b0, vref_lvl}, 10'h050);
		chk({9'h000, pgood_oe}, 10'h000);
		chk({9'h000, pgood_o}, 10'h000);
		@(posedge clk);
		bus_wr(`OSP_A_CLS, 8'hF0);
	endtask
	// Overvoltage is injected through the load model, 10 units above the reference
	task automatic t_prot();
		bump <= 10'h00A;
		bus_wr(`OSP_A_PC1, 8'h1E);
		repeat (20) @(negedge clk);
		chk({9'h000, hs_en}, 10'h001);
		@(posedge clk);
		bus_wr(`OSP_A_PC1, 8'h1F);
		wait_sig(0, 1'b0, 10, n);
		chk({9'h000, snap_ls}, 10'h001);
		bus_rd(`OSP_A_ST, 8'hDE, 8'hDF);
		bump <= 10'h000;
		wait_sig(0, 1'b1, 100, n);
		chk_rng(n, RETRY - 10, RETRY + 10);
		wait_sig(1, 1'b1, 2000, n);
		bus_rd(`OSP_A_ST, 8'hFF, 8'hDF);
		bus_wr(`OSP_A_PC1, 8'h3F);
		bump <= 10'h00A;
		wait_sig(0, 1'b0, 10, n);
		bump <= 10'h000;
		repeat (RETRY + 30) @(negedge clk);
		chk({9'h000, hs_en}, 10'h000);
		@(posedge clk);
		bus_wr(`OSP_A_ST, 8'hFF);
		wait_sig(0, 1'b1, 40, n);
		chk_rng(n, 1, 30);
		wait_sig(1, 1'b1, 2000, n);
		power_off();
		power_on(8'h78);
		bump <= 10'h00A;
		repeat (20) @(negedge clk);
		chk({9'h000, hs_en}, 10'h001);
		@(posedge clk);
		bump <= 10'h000;
		power_off();
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			close_out();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_setpoint();
		t_delays();
		t_droop();
		t_prot();
		close_out();
	end
endmodule // tb_output_sequencing_protection
`default_nettype wire
